// ==== rtl/adcs_pkg.sv ====
// Shared constants, register map and helpers for the conversion sequencer.
package adcs_pkg;

    // ****************************************************************
    // Register map (byte addresses on the APB)
    // ****************************************************************
    localparam logic [7:0] ADCS_CTRL_OFS = 8'h00;
    localparam logic [7:0] ADCS_INSEL_OFS = 8'h04;
    localparam logic [7:0] ADCS_RESULT_OFS = 8'h08;
    localparam logic [7:0] ADCS_STATUS_OFS = 8'h0C;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int ADCS_EN_BIT = 7;
    localparam int ADCS_START_BIT = 6;
    localparam int ADCS_AUTO_BIT = 5;
    localparam int ADCS_DONE_BIT = 4;
    localparam int ADCS_FREE_BIT = 3;
    localparam int ADCS_DIV_LSB = 0;
    localparam int ADCS_DIV_W = 3;
    localparam int ADCS_CHAN_LSB = 0;
    localparam int ADCS_CHAN_W = 4;
    localparam int ADCS_AMP_BIT = 4;
    localparam int ADCS_REF_LSB = 6;
    localparam int ADCS_REF_W = 2;
    localparam int ADCS_RES_W = 10;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [ADCS_DIV_W-1:0] ADCS_DIV_RST = 3'h0;
    localparam logic [ADCS_CHAN_W-1:0] ADCS_CHAN_RST = 4'h0;
    localparam logic [ADCS_REF_W-1:0] ADCS_REF_RST = 2'h0;
    localparam logic [ADCS_RES_W-1:0] ADCS_RES_RST = 10'h000;

    // ****************************************************************
    // Conversion timing in converter clock cycles
    // ****************************************************************
    localparam int ADCS_CYC_W = 5;
    localparam logic [ADCS_CYC_W-1:0] ADCS_NORM_CYCLES = 5'd13;
    localparam logic [ADCS_CYC_W-1:0] ADCS_FIRST_CYCLES = 5'd25;
    localparam logic [ADCS_CYC_W-1:0] ADCS_AUTO_CYCLES = 5'd12;
    localparam logic [ADCS_CYC_W-1:0] ADCS_NORM_SH = 5'd3;
    localparam logic [ADCS_CYC_W-1:0] ADCS_FIRST_SH = 5'd13;
    localparam logic [ADCS_CYC_W-1:0] ADCS_AUTO_SH = 5'd2;
    // Trigger synchroniser depth in CPU clock cycles.
    localparam int ADCS_TRIG_SYNC = 3;
    localparam int ADCS_PRE_W = 8;

    // Select 0 and 1 both give divide by two; select n gives two to the n.
    function automatic logic [ADCS_PRE_W-1:0] adcsDivide(input logic [ADCS_DIV_W-1:0] sel);
        logic [ADCS_PRE_W-1:0] d;
        d = 8'h01 << sel;
        if (sel == 3'h0)
        begin
            d = 8'h02;
        end
        return d;
    endfunction

endpackage

// ==== rtl/adcs_prescaler.sv ====
// Converter clock prescaler producing rising and falling edge strobes.
`timescale 1ns/10ps
module adcs_prescaler
    import adcs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic restart,
    input wire logic [ADCS_DIV_W-1:0] divSel,
    output logic riseTick,
    output logic fallTick,
    output logic convClk
);

    logic [ADCS_PRE_W-1:0] count;
    logic [ADCS_PRE_W-1:0] next_count;
    logic next_riseTick;
    logic next_fallTick;
    logic next_convClk;
    logic [ADCS_PRE_W-1:0] divide;

    always_comb
    begin
        divide = adcsDivide(divSel);
        next_riseTick = 1'b0;
        next_fallTick = 1'b0;
        next_convClk = convClk;
        // Held at zero whenever the converter is off or a trigger restarts it.
        if (!run || restart)
        begin
            next_count = '0;
            next_convClk = 1'b0;
        end
        else if (count == divide - 8'h01)
        begin
            next_count = '0;
            next_riseTick = 1'b1;
            next_convClk = 1'b1;
        end
        else
        begin
            next_count = count + 8'h01;
            if (count == (divide >> 1) - 8'h01)
            begin
                next_fallTick = 1'b1;
                next_convClk = 1'b0;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            count <= '0;
            riseTick <= 1'b0;
            fallTick <= 1'b0;
            convClk <= 1'b0;
        end
        else
        begin
            count <= next_count;
            riseTick <= next_riseTick;
            fallTick <= next_fallTick;
            convClk <= next_convClk;
        end
    end

endmodule

// ==== rtl/adcs_sequencer.sv ====
// Successive-approximation conversion sequencer with APB register access.
//
// What this block does
// - Prescaler runs only while converter enabled.
// - Converter clock divided down from CPU clock.
// - Start bit begins conversion next converter edge.
// - Normal 13 cycles, first one 25.
// - Sample-hold at 3.5, first at 13.5.
// - Completion stores result, flags, clears start.
// - Start set again restarts at next edge.
// - Trigger resets prescaler for fixed delay.
// - Auto sample-hold two cycles plus sync.
// - Free running restarts, start bit stays set.
// - Selection buffered, copied while idle.
// - Selection frozen once conversion starts.
// - Copying resumes in final converter cycle.
// - Free running change affects conversion after next.
// - Amplified conversion clears start bit.
// - Start bit reads one while converting.
// - Trigger edges during conversion are ignored.
`timescale 1ns/10ps
module adcs_sequencer
    import adcs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic trigIn,
    input wire logic [ADCS_RES_W-1:0] compResult,
    output logic sampleHold,
    output logic convActive,
    output logic [ADCS_CHAN_W-1:0] channel_select,
    output logic [ADCS_REF_W-1:0] ref_select,
    output logic ampActive
);

    typedef enum logic [1:0] {ADCS_IDLE, ADCS_WAIT_EDGE, ADCS_CONV} adcs_state_t;

    // ****************************************************************
    // Register bus
    // ****************************************************************
    logic conv_enable;
    logic auto_trig_enable;
    logic freeRun;
    logic [ADCS_DIV_W-1:0] clk_div_select;
    logic [ADCS_CHAN_W-1:0] bufChannel;
    logic [ADCS_REF_W-1:0] bufRef;
    logic bufAmp;
    logic next_conv_enable;
    logic next_auto_trig_enable;
    logic next_freeRun;
    logic [ADCS_DIV_W-1:0] next_clk_div_select;
    logic [ADCS_CHAN_W-1:0] next_bufChannel;
    logic [ADCS_REF_W-1:0] next_bufRef;
    logic next_bufAmp;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic accessDone;
    logic wrCtrl;
    logic mapped;

    // Conversion state.
    adcs_state_t state;
    adcs_state_t next_state;
    logic [ADCS_CYC_W-1:0] cycle;
    logic [ADCS_CYC_W-1:0] next_cycle;
    logic firstConv;
    logic next_firstConv;
    logic autoRun;
    logic next_autoRun;
    logic start_conv;
    logic next_start_conv;
    logic conv_done_flag;
    logic next_conv_done_flag;
    logic [ADCS_RES_W-1:0] result;
    logic [ADCS_RES_W-1:0] next_result;
    logic locked;
    logic next_locked;
    logic next_sampleHold;
    logic next_convActive;
    logic [ADCS_CHAN_W-1:0] next_channel_select;
    logic [ADCS_REF_W-1:0] next_ref_select;
    logic next_ampActive;
    logic presRestart;
    logic [ADCS_CYC_W-1:0] convLen;
    logic [ADCS_CYC_W-1:0] shCycle;

    // Trigger synchroniser.
    logic [ADCS_TRIG_SYNC-1:0] trigSync;
    logic trigEdge;

    logic riseTick;
    logic fallTick;

    adcs_prescaler i_adcs_prescaler (
        .clk(clk),
        .rst_n(rst_n),
        .run(conv_enable),
        .restart(presRestart),
        .divSel(clk_div_select),
        .riseTick(riseTick),
        .fallTick(fallTick),
        .convClk()
    );

    // One wait state: pready rises in the second access cycle.
    assign accessDone = psel && penable && pready;
    assign wrCtrl = accessDone && pwrite && (paddr == ADCS_CTRL_OFS);
    assign mapped = (paddr == ADCS_CTRL_OFS) || (paddr == ADCS_INSEL_OFS) ||
                    (paddr == ADCS_RESULT_OFS) || (paddr == ADCS_STATUS_OFS);

    always_comb
    begin
        next_conv_enable = conv_enable;
        next_auto_trig_enable = auto_trig_enable;
        next_freeRun = freeRun;
        next_clk_div_select = clk_div_select;
        next_bufChannel = bufChannel;
        next_bufRef = bufRef;
        next_bufAmp = bufAmp;
        next_pready = psel && penable && !pready;
        next_pslverr = psel && penable && !pready && !mapped;
        next_prdata = prdata;
        if (psel && penable && !pready)
        begin
            next_prdata = 32'h0000_0000;
            if (!pwrite && paddr == ADCS_CTRL_OFS)
            begin
                next_prdata[ADCS_EN_BIT] = conv_enable;
                next_prdata[ADCS_START_BIT] = start_conv || convActive;
                next_prdata[ADCS_AUTO_BIT] = auto_trig_enable;
                next_prdata[ADCS_DONE_BIT] = conv_done_flag;
                next_prdata[ADCS_FREE_BIT] = freeRun;
                next_prdata[ADCS_DIV_LSB +: ADCS_DIV_W] = clk_div_select;
            end
            else if (!pwrite && paddr == ADCS_INSEL_OFS)
            begin
                next_prdata[ADCS_CHAN_LSB +: ADCS_CHAN_W] = bufChannel;
                next_prdata[ADCS_AMP_BIT] = bufAmp;
                next_prdata[ADCS_REF_LSB +: ADCS_REF_W] = bufRef;
            end
            else if (!pwrite && paddr == ADCS_RESULT_OFS)
            begin
                next_prdata[ADCS_RES_W-1:0] = result;
            end
            else if (!pwrite && paddr == ADCS_STATUS_OFS)
            begin
                next_prdata[ADCS_CHAN_LSB +: ADCS_CHAN_W] = channel_select;
                next_prdata[ADCS_AMP_BIT] = ampActive;
                next_prdata[ADCS_REF_LSB +: ADCS_REF_W] = ref_select;
                next_prdata[8] = convActive;
                next_prdata[9] = firstConv;
            end
        end
        if (wrCtrl)
        begin
            next_conv_enable = pwdata[ADCS_EN_BIT];
            next_auto_trig_enable = pwdata[ADCS_AUTO_BIT];
            next_freeRun = pwdata[ADCS_FREE_BIT];
            next_clk_div_select = pwdata[ADCS_DIV_LSB +: ADCS_DIV_W];
        end
        // Writes land in the buffer only; the analog side never sees them directly.
        if (accessDone && pwrite && paddr == ADCS_INSEL_OFS)
        begin
            next_bufChannel = pwdata[ADCS_CHAN_LSB +: ADCS_CHAN_W];
            next_bufAmp = pwdata[ADCS_AMP_BIT];
            next_bufRef = pwdata[ADCS_REF_LSB +: ADCS_REF_W];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            conv_enable <= 1'b0;
            auto_trig_enable <= 1'b0;
            freeRun <= 1'b0;
            clk_div_select <= ADCS_DIV_RST;
            bufChannel <= ADCS_CHAN_RST;
            bufRef <= ADCS_REF_RST;
            bufAmp <= 1'b0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            conv_enable <= next_conv_enable;
            auto_trig_enable <= next_auto_trig_enable;
            freeRun <= next_freeRun;
            clk_div_select <= next_clk_div_select;
            bufChannel <= next_bufChannel;
            bufRef <= next_bufRef;
            bufAmp <= next_bufAmp;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ****************************************************************
    // Trigger synchronisation
    // ****************************************************************
    // The edge is judged on the last two stages, which costs three CPU cycles.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            trigSync <= '0;
        end
        else
        begin
            trigSync <= {trigSync[ADCS_TRIG_SYNC-2:0], trigIn};
        end
    end

    assign trigEdge = trigSync[ADCS_TRIG_SYNC-2] && !trigSync[ADCS_TRIG_SYNC-1];

    // ****************************************************************
    // Conversion sequencing
    // ****************************************************************
    always_comb
    begin
        next_state = state;
        next_cycle = cycle;
        next_firstConv = firstConv;
        next_autoRun = autoRun;
        next_start_conv = start_conv;
        next_result = result;
        next_locked = locked;
        next_sampleHold = 1'b0;
        presRestart = 1'b0;
        // Clear first so that a completion in the same cycle still sets the flag.
        next_conv_done_flag = conv_done_flag;
        if (wrCtrl && pwdata[ADCS_DONE_BIT])
        begin
            next_conv_done_flag = 1'b0;
        end
        if (firstConv)
        begin
            convLen = ADCS_FIRST_CYCLES;
            shCycle = ADCS_FIRST_SH;
        end
        else if (autoRun)
        begin
            convLen = ADCS_AUTO_CYCLES;
            shCycle = ADCS_AUTO_SH - 5'd1;
        end
        else
        begin
            convLen = ADCS_NORM_CYCLES;
            shCycle = ADCS_NORM_SH;
        end
        if (!conv_enable)
        begin
            next_state = ADCS_IDLE;
            next_start_conv = 1'b0;
            next_firstConv = 1'b1;
            next_locked = 1'b0;
            next_autoRun = 1'b0;
        end
        else
        begin
            case (state)
                ADCS_IDLE:
                begin
                    if (start_conv)
                    begin
                        next_state = ADCS_WAIT_EDGE;
                    end
                    else if (trigEdge && auto_trig_enable && !freeRun)
                    begin
                        presRestart = 1'b1;
                        next_state = ADCS_CONV;
                        next_cycle = '0;
                        next_autoRun = 1'b1;
                        next_locked = 1'b1;
                    end
                end
                ADCS_WAIT_EDGE:
                begin
                    if (riseTick)
                    begin
                        next_state = ADCS_CONV;
                        next_cycle = '0;
                        next_autoRun = 1'b0;
                        next_locked = 1'b1;
                    end
                end
                ADCS_CONV:
                begin
                    // Trigger edges are not looked at in this state.
                    if (autoRun && !firstConv && riseTick && cycle == shCycle)
                    begin
                        next_sampleHold = 1'b1;
                    end
                    else if ((firstConv || !autoRun) && fallTick && cycle == shCycle)
                    begin
                        next_sampleHold = 1'b1;
                    end
                    if (riseTick)
                    begin
                        next_cycle = cycle + 5'd1;
                        if (cycle == convLen - 5'd2)
                        begin
                            next_locked = 1'b0;
                        end
                        if (cycle == convLen - 5'd1)
                        begin
                            next_result = compResult;
                            next_conv_done_flag = 1'b1;
                            next_firstConv = 1'b0;
                            next_cycle = '0;
                            // Amplified channels cannot free-run on their own.
                            if (auto_trig_enable && freeRun && !ampActive)
                            begin
                                next_locked = 1'b1;
                                next_autoRun = 1'b0;
                            end
                            else
                            begin
                                next_state = ADCS_IDLE;
                                next_start_conv = 1'b0;
                                next_autoRun = 1'b0;
                            end
                        end
                    end
                end
                default:
                begin
                    next_state = ADCS_IDLE;
                end
            endcase
        end
        if (wrCtrl && pwdata[ADCS_EN_BIT] && pwdata[ADCS_START_BIT])
        begin
            next_start_conv = 1'b1;
        end
        next_convActive = (next_state == ADCS_CONV);
        next_channel_select = channel_select;
        next_ref_select = ref_select;
        next_ampActive = ampActive;
        if (!locked)
        begin
            next_channel_select = bufChannel;
            next_ref_select = bufRef;
            next_ampActive = bufAmp;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state <= ADCS_IDLE;
            cycle <= '0;
            firstConv <= 1'b1;
            autoRun <= 1'b0;
            start_conv <= 1'b0;
            conv_done_flag <= 1'b0;
            result <= ADCS_RES_RST;
            locked <= 1'b0;
            sampleHold <= 1'b0;
            convActive <= 1'b0;
            channel_select <= ADCS_CHAN_RST;
            ref_select <= ADCS_REF_RST;
            ampActive <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cycle <= next_cycle;
            firstConv <= next_firstConv;
            autoRun <= next_autoRun;
            start_conv <= next_start_conv;
            conv_done_flag <= next_conv_done_flag;
            result <= next_result;
            locked <= next_locked;
            sampleHold <= next_sampleHold;
            convActive <= next_convActive;
            channel_select <= next_channel_select;
            ref_select <= next_ref_select;
            ampActive <= next_ampActive;
        end
    end

endmodule

// ==== tb/adcs_sequencer_monitor.sv ====
// Port-level assertion checker for the conversion sequencer.
`timescale 1ns/10ps
module adcs_seq_checker
    import adcs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic trigIn,
    input wire logic [ADCS_RES_W-1:0] compResult,
    input wire logic sampleHold,
    input wire logic convActive,
    input wire logic [ADCS_CHAN_W-1:0] channel_select,
    input wire logic [ADCS_REF_W-1:0] ref_select,
    input wire logic ampActive
);
    // ****************************************************************
    // Shadow of the enable bit and the selection buffer
    // ****************************************************************
    logic wrDone;
    logic enOn;
    logic next_enOn;
    logic [7:0] bufSel;
    logic [7:0] next_bufSel;

    assign wrDone = psel && penable && pready && pwrite && !pslverr;

    always_comb
    begin
        next_enOn = enOn;
        next_bufSel = bufSel;
        if (wrDone && paddr == ADCS_CTRL_OFS)
        begin
            next_enOn = pwdata[ADCS_EN_BIT];
        end
        if (wrDone && paddr == ADCS_INSEL_OFS)
        begin
            next_bufSel = pwdata[7:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            enOn <= 1'b0;
            bufSel <= 8'h00;
        end
        else
        begin
            enOn <= next_enOn;
            bufSel <= next_bufSel;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_ready_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("pslverr without pready or with data");
    a_sh_in_conv: assert property (sampleHold |-> convActive)
        else $error("sample hold outside a conversion");
    a_off_idle: assert property (!enOn [*2] |-> !convActive && !sampleHold)
        else $error("converter active while disabled");
    a_sel_locked: assert property ($rose(convActive)
        |=> $stable({channel_select, ref_select, ampActive}) [*8])
        else $error("selection changed during conversion");
    a_sel_follows: assert property (!convActive && !$past(convActive) && $stable(bufSel)
        |-> channel_select == bufSel[3:0] && ref_select == bufSel[7:6]
        && ampActive == bufSel[4])
        else $error("selection not copied while idle");
    a_start_reads_one: assert property (psel && penable && pready && !pwrite
        && paddr == ADCS_CTRL_OFS && convActive && $past(convActive)
        |-> prdata[ADCS_START_BIT])
        else $error("start bit low during conversion");
endmodule

bind adcs_sequencer adcs_seq_checker i_adcs_seq_checker (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .trigIn(trigIn),
    .compResult(compResult), .sampleHold(sampleHold), .convActive(convActive),
    .channel_select(channel_select), .ref_select(ref_select), .ampActive(ampActive));

// ==== tb/adcs_sequencer_test.sv ====
// Directed register-level testbench for the conversion sequencer.
`timescale 1ns/10ps
module adcs_sequencer_test
    import adcs_pkg::*;
();
    localparam logic [7:0] oCtl = ADCS_CTRL_OFS;
    localparam logic [7:0] oSel = ADCS_INSEL_OFS;
    localparam logic [7:0] oRes = ADCS_RESULT_OFS;
    localparam logic [7:0] oSts = ADCS_STATUS_OFS;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, trigIn;
    logic sampleHold, convActive, ampActive, lastErr, wasAct;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, lastData;
    logic [ADCS_RES_W-1:0] compResult;
    logic [ADCS_CHAN_W-1:0] channel_select;
    logic [ADCS_REF_W-1:0] ref_select;
    int n_fail, total_checks, cnt, width, shOfs, nConv, d, k;

    adcs_sequencer i_adcs_sequencer (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .trigIn(trigIn),
        .compResult(compResult), .sampleHold(sampleHold), .convActive(convActive),
        .channel_select(channel_select), .ref_select(ref_select), .ampActive(ampActive));

    // ****************************************************************
    // Tasks and conversion timing monitor
    // ****************************************************************
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Holds the request until pready is sampled high, then releases it.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
        begin
            @(posedge clk);
        end
        lastData = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
        input string name);
        apb(1'b0, a, 32'h0);
        chk(name, e, lastData & m);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // The extra edge at the end lets the monitor record the width first.
    task automatic waitConv();
        int n;
        n = 0;
        while (convActive !== 1'b1 && n < 400)
        begin
            @(posedge clk);
            n++;
        end
        n = 0;
        while (convActive !== 1'b0 && n < 4000)
        begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
    endtask

    always @(posedge clk)
    begin
        if (convActive === 1'b1)
        begin
            if (sampleHold === 1'b1)
                shOfs = cnt;
            if (!wasAct)
                nConv++;
            cnt++;
        end
        else if (cnt != 0)
        begin
            width = cnt;
            cnt = 0;
        end
        wasAct = (convActive === 1'b1);
    end

    task automatic stop_test();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ****************************************************************
    // Clock, watchdog and test sequence
    // ****************************************************************
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        repeat (50000) @(posedge clk);
        n_fail++;
        $display("FAIL watchdog expected finish seen timeout");
        stop_test();
    end

    initial
    begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        trigIn = 1'b0;
        compResult = 10'h2A5;
        wasAct = 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd(oCtl, 32'hFF, 32'h0, "ctrl reset");
        rd(oRes, 32'h3FF, 32'h0, "result reset");
        rd(8'h10, 32'hFFFFFFFF, 32'h0, "unmapped data");
        chk("unmapped error", 32'h1, 32'(lastErr));
        apb(1'b1, oSel, 32'h45);
        rd(oSel, 32'hFF, 32'h45, "select buffer");
        rd(oSts, 32'hDF, 32'h45, "active select idle");
        apb(1'b1, oCtl, 32'hC1);
        cyc(10);
        rd(oCtl, 32'h40, 32'h40, "start while busy");
        apb(1'b1, oSel, 32'h03);
        chk("locked channel", 32'h5, 32'(channel_select));
        waitConv();
        chk("first width", 32'd50, width);
        chk("first hold", 32'd27, shOfs);
        rd(oRes, 32'h3FF, 32'h2A5, "first result");
        rd(oCtl, 32'h50, 32'h10, "done set start clear");
        chk("channel after", 32'h3, 32'(channel_select));
        for (int s = 0; s < 8; s++)
        begin
            d = (s == 0) ? 2 : (1 << s);
            compResult <= 10'h100 + 10'(s);
            apb(1'b1, oCtl, 32'hD0 | s);
            waitConv();
            chk("normal width", 13 * d, width);
            chk("normal hold", 3 * d + d / 2, shOfs);
            rd(oRes, 32'h3FF, 32'h100 + s, "normal result");
        end
        apb(1'b1, oCtl, 32'h0);
        k = nConv;
        apb(1'b1, oCtl, 32'h40);
        cyc(60);
        chk("no conv disabled", k, nConv);
        apb(1'b1, oCtl, 32'hC1);
        waitConv();
        chk("re-enable width", 32'd50, width);
        apb(1'b1, oCtl, 32'hB1);
        cyc(5);
        k = nConv;
        trigIn <= 1'b1;
        cyc(2);
        trigIn <= 1'b0;
        cyc(6);
        trigIn <= 1'b1;
        cyc(2);
        trigIn <= 1'b0;
        waitConv();
        chk("one auto conv", k + 1, nConv);
        // The trigger restarts the prescaler at the edge that raises convActive, so the
        // first tick reaches the sequencer one clock later than in a started conversion.
        chk("auto width", 2 * ADCS_AUTO_CYCLES + 1, width);
        chk("auto hold", 2 * ADCS_AUTO_SH + 1, shOfs);
        apb(1'b1, oSel, 32'h41);
        apb(1'b1, oCtl, 32'hF9);
        cyc(80);
        rd(oCtl, 32'h40, 32'h40, "free start stays");
        compResult <= 10'h155;
        apb(1'b1, oSel, 32'h42);
        cyc(80);
        rd(oRes, 32'h3FF, 32'h155, "free result");
        chk("free new channel", 32'h2, 32'(channel_select));
        apb(1'b1, oSel, 32'h52);
        cyc(80);
        rd(oCtl, 32'h40, 32'h0, "amp clears start");
        chk("amp stops", 32'h0, 32'(convActive));
        stop_test();
    end
endmodule
